// ==== verif/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
	import relay_pkg::*;
	logic       i_clk;
	logic       i_rst_n;
	logic       i_power_lost;
	logic       o_q;
	relay_in_s  i_in;
	relay_cfg_s i_cfg;
	int         err_count;
	int         total_checks;
	set_reset_toggle_relay set_reset_toggle_relay_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_power_lost(i_power_lost), .i_in(i_in), .i_cfg(i_cfg), .o_q(o_q));
	// Clock, 20 ns period
	initial begin
		i_clk = 1'h0;
		forever #10 i_clk = ~i_clk;
	end
	// Apply inputs for one cycle, then compare the output
	task automatic st(input logic s, input logic c, input logic t, input logic exp);
		i_in = '{s, c, t};
		@(posedge i_clk);
		#1;
		total_checks++;
		if (o_q !== exp) begin
			err_count++;
			$display("BAD %0t q=%b expected %b", $time, o_q, exp);
		end
	endtask
	// Latch mode truth table
	task automatic latch_case;
		i_cfg = '{MODE_LATCH, 1'h0, 1'h0};
		st(1, 0, 0, 1);
		st(0, 0, 1, 1);
		st(1, 1, 0, 0);
		st(1, 0, 0, 1);
		st(0, 1, 0, 0);
	endtask
	// Toggle edges and overrides
	task automatic toggle_case;
		i_cfg = '{MODE_TOGGLE, 1'h0, 1'h0};
		st(0, 1, 0, 0);
		st(0, 0, 1, 1);
		st(0, 0, 0, 1);
		st(0, 0, 1, 0);
		st(0, 1, 0, 0);
		st(0, 1, 1, 0);
		st(0, 0, 1, 0);
		st(1, 0, 1, 1);
		st(1, 0, 0, 1);
	endtask
	// Both overrides under each dominance
	task automatic dominance_case;
		for (int d = 0; d < 2; d++) begin
			i_cfg = '{MODE_TOGGLE, d[0], 1'h0};
			st(!d[0], d[0], 0, !d[0]);
			st(1, 1, 1, d[0]);
			st(1, 1, 0, d[0]);
		end
	endtask
	// Power loss with and without retention
	task automatic power_case(input relay_mode_e m, input logic r);
		i_cfg = '{m, 1'h0, r};
		st(1, 0, 0, 1);
		i_power_lost = 1'h1;
		st(0, 0, 0, r);
		i_power_lost = 1'h0;
		st(0, 0, 0, r);
	endtask
	// Report counts and verdict
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Reset pulse: output cleared, then a high trigger counts as an edge
	task automatic reset_case;
		i_rst_n = 1'h0;
		st(0, 0, 1, 0);
		i_rst_n = 1'h1;
		st(0, 0, 1, 1);
	endtask
	// Main sequence
	initial begin
		err_count = 0;
		total_checks = 0;
		i_rst_n = 1'h0;
		i_power_lost = 1'h0;
		i_in = '{1'h0, 1'h0, 1'h0};
		i_cfg = '{MODE_TOGGLE, 1'h0, 1'h0};
		repeat (7) @(posedge i_clk);
		#1;
		reset_case();
		latch_case();
		toggle_case();
		dominance_case();
		power_case(MODE_LATCH, 1'h1);
		power_case(MODE_TOGGLE, 1'h0);
		power_case(MODE_TOGGLE, 1'h1);
		reset_case();
		tally_and_finish();
	end
endmodule

// ==== verilog/relay_pkg.sv ====
package relay_pkg;

	// ------------------------------------------------------------
	// Modes and configuration
	// ------------------------------------------------------------
	typedef enum logic {
		MODE_LATCH,
		MODE_TOGGLE
	} relay_mode_e;

	// Block inputs from the circuit program, sampled each cycle
	typedef struct packed {
		logic set;
		logic clr;
		logic trig;
	} relay_in_s;

	// Static configuration
	typedef struct packed {
		relay_mode_e mode;
		logic        set_dominant;   // 1: set wins in toggle mode, 0: clear_dominant
		logic        retain;         // 1: state kept over power loss
	} relay_cfg_s;

	// Reset values
	localparam logic STATE_RST = 1'h0;
	localparam logic TRIG_RST  = 1'h0;

endpackage

// ==== verilog/set_reset_toggle_relay.sv ====
`timescale 1ns/1ns
// Contract
// RL1 - Latch: set drives high, reset drives low
// RL2 - Latch: both active forces output low
// RL3 - Latch: both idle holds previous output
// RL4 - Latch retentive: state survives power loss
// RL5 - Toggle: trigger rising edge inverts output
// RL6 - Toggle: trigger ignored while set or reset
// RL7 - Toggle: only set drives output high
// RL8 - Toggle: only reset drives output low
// RL9 - Toggle: selectable reset or set dominance
// RL10 - Toggle both active: dominance decides output
// RL11 - Toggle non-retentive: power loss clears state
// RL12 - Edge by previous sample; reset output zero
module set_reset_toggle_relay (
	input  wire logic                  i_clk,         // Program-cycle clock
	input  wire logic                  i_rst_n,       // Power-on reset, sync, active low
	input  wire logic                  i_power_lost,  // Power loss and restore event pulse
	input  wire relay_pkg::relay_in_s  i_in,          // Set, clear, trigger
	input  wire relay_pkg::relay_cfg_s i_cfg,         // Mode, dominance, retention
	output logic                       o_q            // Relay output
);
	import relay_pkg::*;

	// ------------------------------------------------------------
	// Decoding
	// ------------------------------------------------------------
	// Mode decode shared by the next-state logic and the checks
	function automatic logic in_toggle(input relay_cfg_s cfg_v);
		in_toggle = (cfg_v.mode == MODE_TOGGLE);
	endfunction

	// Either override input active; masks the trigger in toggle mode
	function automatic logic any_override(input relay_in_s in_v);
		any_override = in_v.set | in_v.clr;
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic state;
	logic trig_prev;
	logic next_state;
	logic next_trig_prev;
	logic trig_rise;

	// Rising trigger edge against the previous cycle's sample
	// RL12 edge by sample
	assign trig_rise = i_in.trig & ~trig_prev;

	// Next output and trigger history; priority per cycle is power loss
	// without retention first, then the table of the selected mode. The
	// trigger history always follows the input, so an edge seen during an
	// override is spent and cannot toggle the output later.
	always_comb begin
		next_state     = state;
		next_trig_prev = i_in.trig;
		if (i_power_lost && !i_cfg.retain) begin
			// RL4 RL11 retention choice
			next_state = STATE_RST;
		end else if (!in_toggle(i_cfg)) begin
			// RL1 RL2 RL3 latch table
			if (i_in.clr)
				next_state = 1'h0;
			else if (i_in.set)
				next_state = 1'h1;
		end else begin
			// RL9 RL10 dominance choice
			if (i_in.set && i_in.clr)
				next_state = i_cfg.set_dominant;
			// RL7 set only
			else if (i_in.set)
				next_state = 1'h1;
			// RL8 reset only
			else if (i_in.clr)
				next_state = 1'h0;
			// RL5 RL6 gated toggle
			else if (trig_rise)
				next_state = ~state;
		end
	end

	// Registers
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			// RL12 reset output zero
			state     <= STATE_RST;
			trig_prev <= TRIG_RST;
		end else begin
			state     <= next_state;
			trig_prev <= next_trig_prev;
		end
	end

	// Output comes straight from the state register
	assign o_q = state;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// Checks sleep while reset is held; the two reset checks opt out below

	// High once a real trigger sample exists, so edge checks skip reset
	logic live;
	logic next_live;

	// Next value of the check window flag
	always_comb begin
		next_live = 1'h1;
	end

	// Check window register
	always_ff @(posedge i_clk) begin
		if (!i_rst_n)
			live <= 1'h0;
		else
			live <= next_live;
	end

	// Trigger low, then high one cycle later
	sequence s_rise;
		!i_in.trig ##1 i_in.trig;
	endsequence

	// Toggle mode, both overrides quiet, no power event
	sequence s_toggle_free;
		in_toggle(i_cfg) && !any_override(i_in) && !i_power_lost;
	endsequence

	// Trigger rises while an override holds it off
	sequence s_masked_rise;
		!i_in.trig ##1 (i_in.trig && in_toggle(i_cfg) && any_override(i_in) && !i_power_lost);
	endsequence

	// Toggle mode with both overrides active
	sequence s_both_over;
		in_toggle(i_cfg) && i_in.set && i_in.clr && !i_power_lost;
	endsequence

	// RL1 latch set
	a_latch_set_high: assert property ( // RL1
		(i_cfg.mode == MODE_LATCH && i_in.set && !i_in.clr && !i_power_lost) |=> o_q)
		else $error("latch set did not drive high");

	// RL2 reset wins
	a_latch_clr_wins: assert property ( // RL2
		(i_cfg.mode == MODE_LATCH && i_in.clr && !i_power_lost) |=> !o_q)
		else $error("latch reset did not drive low");

	// RL3 idle hold
	a_latch_hold_q: assert property ( // RL3
		(i_cfg.mode == MODE_LATCH && !i_in.set && !i_in.clr && !i_power_lost) |=> $stable(o_q))
		else $error("latch idle did not hold");

	// RL4 retention keeps
	a_retain_keeps_q: assert property ( // RL4
		(i_power_lost && i_cfg.retain && !i_in.set && !i_in.clr && !i_in.trig) |=> $stable(o_q))
		else $error("retentive state lost");

	// RL5 edge inverts
	a_toggle_edge_inv: assert property ( // RL5
		live ##0 s_rise ##0 s_toggle_free |=> (o_q != $past(o_q)))
		else $error("trigger edge did not invert");

	// RL5 no edge holds
	a_toggle_no_edge: assert property ( // RL5
		live ##0 s_toggle_free ##0 !(i_in.trig && !$past(i_in.trig)) |=> $stable(o_q))
		else $error("output moved without trigger edge");

	// RL6 spent edge
	a_rise_masked_hold: assert property ( // RL6
		live ##0 s_masked_rise ##1 i_in.trig ##0 s_toggle_free
		|=> $stable(o_q))
		else $error("masked trigger edge acted later");

	// RL6 override masks
	a_toggle_ignore_trg: assert property ( // RL6
		(i_cfg.mode == MODE_TOGGLE && (i_in.set ^ i_in.clr) && !i_power_lost) |=> o_q == $past(i_in.set))
		else $error("override did not mask trigger");

	// RL7 set only
	a_toggle_set_high: assert property ( // RL7
		(in_toggle(i_cfg) && i_in.set && !i_in.clr && !i_power_lost) |=> o_q)
		else $error("toggle set did not drive high");

	// RL8 reset only
	a_toggle_clr_low: assert property ( // RL8
		(in_toggle(i_cfg) && i_in.clr && !i_in.set && !i_power_lost) |=> !o_q)
		else $error("toggle reset did not drive low");

	// RL9 set dominance
	a_set_dom_high: assert property ( // RL9
		s_both_over ##0 i_cfg.set_dominant |=> o_q)
		else $error("set dominance not applied");

	// RL9 reset dominance
	a_clr_dom_low: assert property ( // RL9
		s_both_over ##0 !i_cfg.set_dominant |=> !o_q)
		else $error("reset dominance not applied");

	// RL10 both active
	a_toggle_dominance: assert property ( // RL10
		(i_cfg.mode == MODE_TOGGLE && i_in.set && i_in.clr && !i_power_lost)
		|=> o_q == $past(i_cfg.set_dominant))
		else $error("dominance not applied");

	// RL11 power clears
	a_power_clear_q: assert property ( // RL11
		(i_power_lost && !i_cfg.retain) |=> !o_q [*1])
		else $error("non-retentive state not cleared");

	// RL12 reset zero
	a_reset_zero_q: assert property ( // RL12
		@(posedge i_clk) disable iff (1'h0) !i_rst_n |=> !o_q)
		else $error("output not zero after reset");

	// RL12 first edge
	a_first_edge_rise: assert property ( // RL12
		@(posedge i_clk) disable iff (1'h0)
		!i_rst_n ##1 (i_rst_n && i_in.trig) ##0 s_toggle_free |=> o_q)
		else $error("trigger high after reset did not count as edge");

endmodule
